/* File: verilog/pph_pkg.sv */
package pph_pkg;
    // Register map, 3-bit address, 8-bit data
    localparam logic [2:0] ADDR_PORT_A_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_PORT_B_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_GENERAL_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_PORT_STATUS = 3'h3;
    localparam logic [2:0] ADDR_DIR_A = 3'h4;
    localparam logic [2:0] ADDR_DIR_B = 3'h5;
    localparam logic [2:0] ADDR_DATA_A = 3'h6;
    localparam logic [2:0] ADDR_DATA_B = 3'h7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Control register fields
    localparam int SUBMODE_LSB = 6;
    localparam int LINE_CTRL_HI = 5;
    localparam int LINE_CTRL_MID = 4;
    localparam int LINE_CTRL_LO = 3;
    localparam int EDGE_IRQ_EN_BIT = 2;
    localparam int SVC_EN_BIT = 1;
    localparam int STATUS_CTRL_BIT = 0;
    // General control fields
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int EN34_BIT = 5;
    localparam int EN12_BIT = 4;
    localparam logic [1:0] MODE_UNI16 = 2'h1;
    localparam logic [1:0] MODE_BIDIR8 = 2'h2;
    // Fourth line control codes (upper two bits)
    localparam logic [1:0] LINE4_FIXED = 2'h2;
    localparam logic [1:0] LINE4_HANDSHAKE = 2'h3;
    // Timing, device clock 40 MHz
    localparam int CLK_MHZ = 40;
    localparam int HS_DELAY_CYCLES = 2;
    localparam int PULSE_CYCLES = 4;
    localparam logic [2:0] PULSE_LEN = 3'(PULSE_CYCLES);
    localparam logic [1:0] HS_WAIT_LAST = 2'(HS_DELAY_CYCLES - 2);
endpackage : pph_pkg

/* File: verilog/pph_edge.sv */
`timescale 1ns/1ps
module pph_edge
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic din,
    output logic level,
    output logic rise
);
    logic meta;
    logic sync;

    // Two-stage capture, edge taken from the second stage against the third
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            level <= 1'b0;
        end
        else if (ce)
        begin
            meta <= din;
            sync <= meta;
            level <= sync;
        end
    end

    assign rise = sync & ~level;
endmodule : pph_edge

/* File: verilog/pph_top.sv */
`timescale 1ns/1ps
// Function
// - Line two control: 0XX edge input, 1X0 driven low, 1X1 driven high.
// - Line four control: 0XX input, 100 low, 101 high, 110 interlocked, 111 pulsed.
// - Port A control bit 2 gates the line two status interrupt.
// - Port B control bit 2 gates the line four status interrupt.
// - Port A control bit 1 gates the line one status interrupt in 16-bit mode.
// - Port B control bit 1 gates both service and DMA request from line three.
// - Line one is an edge status input in 16-bit mode; status bit 0 ignored.
// - Input submode: line three flag set whenever unread input data is buffered.
// - Output submode: port A byte waits in temp latch, port B write moves word.
// - Output submode: DMA request asks for another 16-bit word.
// - Line four edge flag set on edge; cleared by reset, write one, disable.
// - Interlocked: line four asserts two clocks after load, drops on line three edge.
// - Handshake codes: line three edges do nothing to output data until line four is armed.
// - Pulsed: line four asserts as interlocked but at most four clocks.
// - Handshake codes keep line four flag clear; line four low while disabled.
// - Output submode: status bit 0 picks can-accept or both-empty line three meaning.
// - Line two edge flag set on edge; cleared by reset, write one, disable.
// - Output submode: input-direction pins still buffer written data, driver off.
// - Bidirectional mode: port A plain bit I/O, port B drives output buffer entry 0 with no line three or four handshake.
// - Bidirectional mode: port B direction follows line one; its direction ignored.
// - Bidirectional mode: port A writes single buffered, driven only where direction is 1.
// - Bidirectional mode: port A read gives pin where direction 0, latch where 1.
// - 16-bit mode sequencing advances on port B data access; A first, B last.
module pph_top
    import pph_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [7:0] PA_IN,
    output logic [7:0] PA_OUT,
    output logic [7:0] PA_OE,
    input wire logic [7:0] PB_IN,
    output logic [7:0] PB_OUT,
    output logic [7:0] PB_OE,
    input wire logic HANDSHAKE_LINE_ONE,
    input wire logic HANDSHAKE_LINE_TWO_IN,
    output logic HANDSHAKE_LINE_TWO_OUT,
    output logic HANDSHAKE_LINE_TWO_OE,
    input wire logic HANDSHAKE_LINE_THREE,
    input wire logic HANDSHAKE_LINE_FOUR_IN,
    output logic HANDSHAKE_LINE_FOUR_OUT,
    output logic HANDSHAKE_LINE_FOUR_OE,
    output logic SERVICE_REQUEST,
    output logic DMA_REQUEST_OUT
);
    logic [7:0] port_a_control;
    logic [7:0] port_b_control;
    logic [7:0] general_control;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] temp_latch;
    logic [7:0] bitio_latch;
    logic [15:0] in_buf [0:1];
    logic [1:0] in_valid;
    logic [15:0] out_buf [0:1];
    logic [1:0] out_valid;
    logic line_one_status_flag;
    logic line_two_status_flag;
    logic line_four_status_flag;
    logic line_three_status_flag;
    logic armed;
    logic [1:0] wait_cnt;
    logic [2:0] pulse_cnt;
    logic [2:0] h4_run;
    logic lvl1, lvl2, lvl3, lvl4;
    logic rise1, rise2, rise3, rise4;

    pph_edge u_edge1 (.clk(CLK), .rst_b(RST_B), .ce(CE), .din(HANDSHAKE_LINE_ONE),
                      .level(lvl1), .rise(rise1));
    pph_edge u_edge2 (.clk(CLK), .rst_b(RST_B), .ce(CE), .din(HANDSHAKE_LINE_TWO_IN),
                      .level(lvl2), .rise(rise2));
    pph_edge u_edge3 (.clk(CLK), .rst_b(RST_B), .ce(CE), .din(HANDSHAKE_LINE_THREE),
                      .level(lvl3), .rise(rise3));
    pph_edge u_edge4 (.clk(CLK), .rst_b(RST_B), .ce(CE), .din(HANDSHAKE_LINE_FOUR_IN),
                      .level(lvl4), .rise(rise4));

    logic [1:0] mode;
    logic en12, en34, uni16, bidir, out_sub, in_sub;
    logic line2_output, line4_output, line4_hs, line4_pulsed;
    logic wr_a, wr_b, rd_b, push, pop_in, capture, drain, load_fol;
    logic hs_ready, h3_take;

    assign mode = general_control[MODE_HI:MODE_LO];
    assign en12 = general_control[EN12_BIT];
    assign en34 = general_control[EN34_BIT];
    assign uni16 = (mode == MODE_UNI16);
    assign bidir = (mode == MODE_BIDIR8);
    assign out_sub = uni16 & port_b_control[SUBMODE_LSB];
    assign in_sub = uni16 & ~port_b_control[SUBMODE_LSB];
    assign line2_output = port_a_control[LINE_CTRL_HI];
    assign line4_output = port_b_control[LINE_CTRL_HI];
    assign line4_hs = port_b_control[LINE_CTRL_HI:LINE_CTRL_MID] == LINE4_HANDSHAKE;
    assign line4_pulsed = line4_hs & port_b_control[LINE_CTRL_LO];
    assign wr_a = CE & WR & (ADDR == ADDR_DATA_A);
    assign wr_b = CE & WR & (ADDR == ADDR_DATA_B);
    assign rd_b = CE & RD & (ADDR == ADDR_DATA_B);

    // Ready means the handshake owner may accept a line three edge
    assign hs_ready = out_sub ? armed : (in_sub & ~in_valid[1] & en34);
    // Without a handshake code the edge alone moves data
    assign h3_take = rise3 & CE & (line4_hs ? hs_ready
                     : (out_sub ? out_valid[0] : ~in_valid[1]));
    assign capture = in_sub & h3_take;
    assign pop_in = in_sub & rd_b & in_valid[0];
    assign drain = out_sub & h3_take & out_valid[0];
    assign push = (out_sub | bidir) & wr_b;
    assign load_fol = push & (~out_valid[0] | (drain & ~out_valid[1]));

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            port_a_control <= CONTROL_RESET;
            port_b_control <= CONTROL_RESET;
            general_control <= CONTROL_RESET;
            dir_a <= CONTROL_RESET;
            dir_b <= CONTROL_RESET;
        end
        else if (CE && WR)
        begin
            unique case (ADDR)
                ADDR_PORT_A_CONTROL: port_a_control <= WDATA;
                ADDR_PORT_B_CONTROL: port_b_control <= WDATA;
                ADDR_GENERAL_CONTROL: general_control <= WDATA;
                ADDR_DIR_A: dir_a <= WDATA;
                ADDR_DIR_B: dir_b <= WDATA;
                default: ;
            endcase
        end
    end

    // Port A byte held until the port B half of the word arrives
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            temp_latch <= 8'h00;
            bitio_latch <= 8'h00;
        end
        else if (wr_a)
        begin
            temp_latch <= WDATA;
            bitio_latch <= WDATA;
        end
    end

    // Input double buffer: entry 0 is the final latch
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            in_valid <= 2'h0;
            in_buf[0] <= 16'h0000;
            in_buf[1] <= 16'h0000;
        end
        else if (CE)
        begin
            if (pop_in)
            begin
                in_buf[0] <= in_buf[1];
                in_valid <= {1'b0, in_valid[1]};
                if (capture && in_valid[1])
                begin
                    in_buf[1] <= {PA_IN, PB_IN};
                    in_valid <= 2'h3;
                end
                else if (capture)
                begin
                    in_buf[0] <= {PA_IN, PB_IN};
                    in_valid <= 2'h1;
                end
            end
            else if (capture)
            begin
                in_buf[in_valid[0]] <= {PA_IN, PB_IN};
                in_valid <= {in_valid[0], 1'b1};
            end
        end
    end

    // Output double buffer; input-direction pins still take the data
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            out_valid <= 2'h0;
            out_buf[0] <= 16'h0000;
            out_buf[1] <= 16'h0000;
        end
        else if (CE)
        begin
            if (drain)
            begin
                out_buf[0] <= out_buf[1];
                out_valid[0] <= out_valid[1];
                out_valid[1] <= 1'b0;
            end
            if (load_fol)
            begin
                out_buf[0] <= {temp_latch, WDATA};
                out_valid[0] <= 1'b1;
            end
            else if (push && !out_valid[1])
            begin
                out_buf[1] <= {temp_latch, WDATA};
                out_valid[1] <= 1'b1;
            end
        end
    end

    // Line four handshake sequencing: load delay for output submode, pulse timing for both submodes
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            armed <= 1'b0;
            wait_cnt <= 2'h0;
            pulse_cnt <= 3'h0;
        end
        else if (CE)
        begin
            if (!en34 || !line4_hs || h3_take || !out_sub)
            begin
                armed <= 1'b0;
                wait_cnt <= 2'h0;
            end
            else if (out_valid[0] && !armed)
            begin
                if (wait_cnt == HS_WAIT_LAST)
                    armed <= 1'b1;
                else
                    wait_cnt <= wait_cnt + 2'h1;
            end
            if (!hs_ready || h3_take)
                pulse_cnt <= 3'h0;
            else if (pulse_cnt < PULSE_LEN)
                pulse_cnt <= pulse_cnt + 3'h1;
        end
    end

    // Edge flags; a new edge beats a write-one clear
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            line_one_status_flag <= 1'b0;
            line_two_status_flag <= 1'b0;
            line_four_status_flag <= 1'b0;
        end
        else if (CE)
        begin
            if (WR && ADDR == ADDR_PORT_STATUS)
            begin
                if (WDATA[0])
                    line_one_status_flag <= 1'b0;
                if (WDATA[1])
                    line_two_status_flag <= 1'b0;
                if (WDATA[3])
                    line_four_status_flag <= 1'b0;
            end
            if (!en12)
                line_one_status_flag <= 1'b0;
            else if (rise1)
                line_one_status_flag <= 1'b1;
            if (!en12 || line2_output)
                line_two_status_flag <= 1'b0;
            else if (rise2)
                line_two_status_flag <= 1'b1;
            if (!en34 || line4_output)
                line_four_status_flag <= 1'b0;
            else if (rise4)
                line_four_status_flag <= 1'b1;
        end
    end

    always_comb
    begin
        if (out_sub)
            line_three_status_flag = port_b_control[STATUS_CTRL_BIT] ? ~|out_valid
                                     : ~&out_valid;
        else
            line_three_status_flag = (in_sub | bidir) & in_valid[0];
    end

    logic next_h4;
    logic next_h2;
    logic [7:0] next_pa_oe;
    logic [7:0] next_pa_out;
    logic [7:0] next_rdata;

    always_comb
    begin
        if (!line4_output)
            next_h4 = 1'b0;
        else if (!line4_hs)
            next_h4 = port_b_control[LINE_CTRL_LO];
        else
            // Drop on the accepting edge so a same-cycle reload never shows line four high
            next_h4 = en34 & hs_ready & ~h3_take
                      & (~line4_pulsed | (pulse_cnt < PULSE_LEN));
        next_h2 = line2_output & port_a_control[LINE_CTRL_LO];
        if (bidir)
        begin
            next_pa_oe = dir_a;
            next_pa_out = bitio_latch;
        end
        else
        begin
            next_pa_oe = dir_a;
            next_pa_out = out_sub ? out_buf[0][15:8] : bitio_latch;
        end
        unique case (ADDR)
            ADDR_PORT_A_CONTROL: next_rdata = port_a_control;
            ADDR_PORT_B_CONTROL: next_rdata = port_b_control;
            ADDR_GENERAL_CONTROL: next_rdata = general_control;
            ADDR_PORT_STATUS: next_rdata = {lvl4, lvl3, lvl2, lvl1,
                line_four_status_flag, line_three_status_flag,
                line_two_status_flag, line_one_status_flag};
            ADDR_DIR_A: next_rdata = dir_a;
            ADDR_DIR_B: next_rdata = dir_b;
            ADDR_DATA_A: next_rdata = in_sub ? ((in_buf[0][15:8] & ~dir_a) | (bitio_latch & dir_a))
                : ((PA_IN & ~dir_a) | (next_pa_out & dir_a));
            ADDR_DATA_B: next_rdata = in_sub ? in_buf[0][7:0] : PB_IN;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            RDATA <= 8'h00;
            PA_OUT <= 8'h00;
            PA_OE <= 8'h00;
            PB_OUT <= 8'h00;
            PB_OE <= 8'h00;
            HANDSHAKE_LINE_TWO_OUT <= 1'b0;
            HANDSHAKE_LINE_TWO_OE <= 1'b0;
            HANDSHAKE_LINE_FOUR_OUT <= 1'b0;
            HANDSHAKE_LINE_FOUR_OE <= 1'b0;
            SERVICE_REQUEST <= 1'b0;
            DMA_REQUEST_OUT <= 1'b0;
        end
        else if (CE)
        begin
            if (RD)
                RDATA <= next_rdata;
            PA_OUT <= next_pa_out;
            PA_OE <= next_pa_oe;
            PB_OUT <= (out_sub | bidir) ? out_buf[0][7:0] : bitio_latch;
            // Line one level, not the direction register, steers port B here
            PB_OE <= bidir ? {8{~lvl1}} : dir_b;
            HANDSHAKE_LINE_TWO_OUT <= next_h2;
            HANDSHAKE_LINE_TWO_OE <= line2_output;
            HANDSHAKE_LINE_FOUR_OUT <= next_h4;
            HANDSHAKE_LINE_FOUR_OE <= line4_output;
            SERVICE_REQUEST <= (port_a_control[EDGE_IRQ_EN_BIT] & line_two_status_flag)
                | (port_b_control[EDGE_IRQ_EN_BIT] & line_four_status_flag)
                | (port_a_control[SVC_EN_BIT] & line_one_status_flag)
                | (port_b_control[SVC_EN_BIT] & line_three_status_flag);
            DMA_REQUEST_OUT <= port_b_control[SVC_EN_BIT] & uni16
                & line_three_status_flag;
        end
    end

    // Consecutive high cycles of line four, for checking only
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
            h4_run <= 3'h0;
        else if (CE)
            h4_run <= (next_h4 && h4_run != 3'h7) ? h4_run + 3'h1 : (next_h4 ? h4_run : 3'h0);
    end

    sequence s_fill;
        CE && en34 && line4_hs && out_sub && load_fol ##1 (CE && en34 && line4_hs && out_sub)[*2];
    endsequence

    a_line2_codes: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && line2_output |=> HANDSHAKE_LINE_TWO_OE && !line_two_status_flag
        && HANDSHAKE_LINE_TWO_OUT == $past(port_a_control[LINE_CTRL_LO]))
        else $error("line two output code not honoured");
    a_line4_fixed: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && port_b_control[5:4] == LINE4_FIXED |=> HANDSHAKE_LINE_FOUR_OE
        && HANDSHAKE_LINE_FOUR_OUT == $past(port_b_control[LINE_CTRL_LO]))
        else $error("line four fixed output wrong");
    a_irq_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && !port_a_control[2] && !port_b_control[2] && !port_a_control[1]
        && !port_b_control[1] |=> !SERVICE_REQUEST)
        else $error("service request with all enables clear");
    a_irq_two: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && port_b_control[2] && line_four_status_flag |=> SERVICE_REQUEST)
        else $error("enabled line four flag gave no request");
    a_dma_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && !port_b_control[SVC_EN_BIT] |=> !DMA_REQUEST_OUT)
        else $error("DMA request while disabled");
    a_input_dma: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && in_sub && port_b_control[SVC_EN_BIT] && in_valid[0] |=> DMA_REQUEST_OUT)
        else $error("unread input gave no DMA request");
    a_empty_dma: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && out_sub && port_b_control[1] && port_b_control[0] && out_valid != 2'h0
        |=> !DMA_REQUEST_OUT)
        else $error("both-empty meaning flagged with data held");
    a_h4_early: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && en34 && line4_hs && out_sub && load_fol |=> !HANDSHAKE_LINE_FOUR_OUT)
        else $error("line four rose before two clocks");
    a_h4_delay: assert property (@(posedge CLK) disable iff (!RST_B)
        s_fill |=> HANDSHAKE_LINE_FOUR_OUT)
        else $error("line four not asserted two clocks after load");
    a_h4_ignore: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && out_sub && line4_hs && !armed && out_valid[0] && !push
        |=> out_buf[0] == $past(out_buf[0]))
        else $error("output data moved while line four negated");
    a_pulse_max: assert property (@(posedge CLK) disable iff (!RST_B)
        line4_pulsed |-> h4_run <= PULSE_LEN)
        else $error("pulsed line four held beyond four clocks");
    a_h4_disabled: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && line4_hs && !en34 |=> !HANDSHAKE_LINE_FOUR_OUT && !line_four_status_flag)
        else $error("line four active while disabled");
    a_flags_disabled: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && !en12 |=> !line_one_status_flag && !line_two_status_flag)
        else $error("line one or two flag set while disabled");
    a_pb_direction: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && bidir |=> PB_OE == {8{!$past(lvl1)}})
        else $error("port B direction not following line one");
    a_pa_bitio: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && bidir |=> PA_OE == $past(dir_a) && PA_OUT == $past(bitio_latch))
        else $error("port A bit I/O drive wrong");
endmodule : pph_top

/* File: testbench/pph_peer.sv */
`timescale 1ns/1ps
module pph_peer
(
    input wire logic clk,
    input wire logic slow,
    input wire logic line_four,
    output logic line_three
);
    logic [1:0] delay = 2'h0;

    initial line_three = 1'b0;

    // A slow peer never answers, so a pulsed offer must time out on its own
    always @(posedge clk)
    begin
        if (!line_four)
        begin
            delay <= 2'h0;
            line_three <= 1'b0;
        end
        else if (!slow && delay != 2'h3)
            delay <= delay + 2'h1;
        else if (!slow)
            line_three <= 1'b1;
    end
endmodule : pph_peer

/* File: testbench/parallel_port_handshake_modes_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module parallel_port_handshake_modes_test
    import pph_pkg::*;
();
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [7:0] pa_in = 8'h00;
    logic [7:0] pb_in = 8'h00;
    logic line_one = 1'b0;
    logic line_two = 1'b0;
    logic slow = 1'b0;
    logic line_three;
    logic [7:0] rdata, pa_out, pa_oe, pb_out, pb_oe;
    logic two_out, two_oe, four_out, four_oe, svc, dma;
    int checks = 0;
    int num_errors = 0;
    wire two_pin = two_oe ? two_out : line_two;
    wire four_pin = four_oe ? four_out : 1'b0;

    always #12.5 clk = ~clk;

    pph_top DUT
    (
        .CLK(clk), .RST_B(rst_b), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
        .WR(wr_strobe), .RD(rd_strobe), .RDATA(rdata), .PA_IN(pa_in),
        .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out),
        .PB_OE(pb_oe), .HANDSHAKE_LINE_ONE(line_one), .HANDSHAKE_LINE_TWO_IN(two_pin),
        .HANDSHAKE_LINE_TWO_OUT(two_out), .HANDSHAKE_LINE_TWO_OE(two_oe),
        .HANDSHAKE_LINE_THREE(line_three), .HANDSHAKE_LINE_FOUR_IN(four_pin),
        .HANDSHAKE_LINE_FOUR_OUT(four_out), .HANDSHAKE_LINE_FOUR_OE(four_oe),
        .SERVICE_REQUEST(svc), .DMA_REQUEST_OUT(dma)
    );

    pph_peer PEER
    (
        .clk(clk), .slow(slow), .line_four(four_out), .line_three(line_three)
    );

    task automatic stop_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd

    // Counts edges until line four reaches the wanted level
    task automatic wait_four(input logic lvl, output int n);
        n = 0;
        #1;
        while (four_out !== lvl)
        begin
            if (n == 20)
            begin
                num_errors++;
                $display("ERROR %0t: line four wait timed out", $time);
                stop_test();
            end
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_four

    task automatic settle(input int cycles);
        repeat (cycles) @(posedge clk);
        #1;
    endtask : settle

    task automatic fixed_codes();
        logic [7:0] d;
        bus_rd(ADDR_PORT_A_CONTROL, d);
        `CHK(d, CONTROL_RESET)
        bus_wr(ADDR_GENERAL_CONTROL, 8'h70);
        bus_wr(ADDR_PORT_A_CONTROL, 8'h20);
        bus_wr(ADDR_PORT_B_CONTROL, 8'h20);
        settle(2);
        `CHK({two_oe, two_out, four_oe, four_out}, 4'b1010)
        bus_wr(ADDR_PORT_A_CONTROL, 8'h2d);
        bus_wr(ADDR_PORT_B_CONTROL, 8'h28);
        settle(2);
        `CHK({two_oe, two_out, four_oe, four_out}, 4'b1111)
        bus_rd(ADDR_PORT_STATUS, d);
        `CHK(d[1], 1'b0)
    endtask : fixed_codes

    task automatic line_two_flag();
        logic [7:0] d;
        bus_wr(ADDR_PORT_A_CONTROL, 8'h00);
        // Pin was driven high before; let the synchroniser see it low first
        settle(4);
        line_two <= 1'b1;
        settle(6);
        bus_rd(ADDR_PORT_STATUS, d);
        `CHK(d[1], 1'b1)
        `CHK(svc, 1'b0)
        bus_wr(ADDR_PORT_A_CONTROL, 8'h04);
        settle(2);
        `CHK(svc, 1'b1)
        bus_wr(ADDR_PORT_STATUS, 8'h02);
        bus_rd(ADDR_PORT_STATUS, d);
        `CHK(d[1], 1'b0)
        line_two <= 1'b0;
    endtask : line_two_flag

    task automatic output_word();
        int n;
        bus_wr(ADDR_DIR_A, 8'hff);
        bus_wr(ADDR_DIR_B, 8'h0f);
        bus_wr(ADDR_PORT_B_CONTROL, 8'h72);
        bus_wr(ADDR_DATA_A, 8'ha5);
        settle(3);
        `CHK({pa_out, four_out}, 9'h000)
        bus_wr(ADDR_DATA_B, 8'h3c);
        wait_four(1'b1, n);
        `CHK(n, 2)
        `CHK(dma, 1'b1)
        `CHK({pa_out, pb_out, pb_oe}, 24'ha53c0f)
        wait_four(1'b0, n);
        `CHK(line_three, 1'b1)
    endtask : output_word

    task automatic pulsed_word();
        logic [7:0] d;
        int n;
        slow <= 1'b1;
        bus_wr(ADDR_PORT_B_CONTROL, 8'h7b);
        bus_rd(ADDR_PORT_B_CONTROL, d);
        `CHK(d, 8'h7b)
        bus_wr(ADDR_DATA_A, 8'h11);
        bus_wr(ADDR_DATA_B, 8'h22);
        wait_four(1'b1, n);
        `CHK(n, 2)
        `CHK(dma, 1'b0)
        wait_four(1'b0, n);
        `CHK(n, PULSE_CYCLES)
        `CHK({pa_out, pb_out}, 16'h1122)
    endtask : pulsed_word

    task automatic bidir_port_a();
        logic [7:0] d;
        bus_wr(ADDR_GENERAL_CONTROL, 8'hb0);
        bus_wr(ADDR_DIR_A, 8'h0f);
        bus_wr(ADDR_DATA_A, 8'h5a);
        pa_in <= 8'h33;
        settle(3);
        bus_rd(ADDR_DATA_A, d);
        `CHK(d, 8'h3a)
        `CHK({pa_oe, pa_out & 8'h0f}, 16'h0f0a)
        `CHK(pb_oe, 8'hff)
        line_one <= 1'b1;
        settle(6);
        `CHK(pb_oe, 8'h00)
    endtask : bidir_port_a

    // One word still unread from the first line three edge
    task automatic input_word();
        logic [7:0] d;
        bus_wr(ADDR_GENERAL_CONTROL, 8'h70);
        bus_wr(ADDR_DIR_A, 8'h00);
        bus_wr(ADDR_PORT_B_CONTROL, 8'h22);
        settle(2);
        `CHK({dma, svc}, 2'h3)
        bus_rd(ADDR_DATA_A, d);
        bus_rd(ADDR_DATA_B, d);
        settle(2);
        `CHK(dma, 1'b0)
        pa_in <= 8'hc3;
        pb_in <= 8'h96;
        slow <= 1'b0;
        bus_wr(ADDR_PORT_B_CONTROL, 8'h2a);
        settle(10);
        `CHK(dma, 1'b1)
        bus_rd(ADDR_DATA_A, d);
        `CHK(d, 8'hc3)
        bus_rd(ADDR_DATA_B, d);
        `CHK(d, 8'h96)
    endtask : input_word

    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        fixed_codes();
        line_two_flag();
        output_word();
        pulsed_word();
        bidir_port_a();
        input_word();
        stop_test();
    end
endmodule : parallel_port_handshake_modes_test
